// ---- shared/swc_pkg.sv ----
package swc_pkg;
  // ==========================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] SWC_ADDR_WDCTL   = 8'h00;
  localparam logic [7:0] SWC_ADDR_OPTION  = 8'h04;
  localparam logic [7:0] SWC_ADDR_CONFIG  = 8'h08;
  localparam logic [7:0] SWC_ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] SWC_ADDR_ID0     = 8'h10;
  localparam logic [7:0] SWC_ADDR_PROG    = 8'h20;
  // ==========================================
  // Reset values and write masks
  localparam logic [7:0] SWC_WDCTL_RST    = 8'h08;
  localparam logic [7:0] SWC_OPTION_RST   = 8'hFF;
  localparam logic [7:0] SWC_CONFIG_RST   = 8'h00;
  localparam logic [7:0] SWC_WDCTL_MASK   = 8'h1F;
  localparam logic [6:0] SWC_ID_MASK      = 7'h7F;
  // ==========================================
  // Field positions
  localparam int SWC_WD_SOFT_EN_BIT  = 0;
  localparam int SWC_WD_PS_LSB       = 1;
  localparam int SWC_CFG_WDT_EN_BIT  = 3;
  localparam int SWC_CFG_FOSC_LSB    = 0;
  localparam logic [2:0] SWC_FOSC_RC_IO_MODE = 3'h5;
  localparam logic [2:0] SWC_FOSC_EC   = 3'h3;
  localparam int SWC_ID_WORDS        = 4;
  // ==========================================
  // Timing
  localparam int SWC_OST_PERIODS     = 1024;
  localparam int SWC_WDT_BASE_CYCLES = 32;
  // ==========================================
  // AHB and controller states
  localparam logic [1:0] SWC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SWC_HSIZE_WORD    = 3'h2;
  typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_OST} swc_state_t;
endpackage

// ---- src/swc_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Sleep entered only by sleep instruction
// [R2] Sleep clears watchdog, watchdog keeps counting
// [R3] Sleep clears power-down flag, sets timeout
// [R4] Sleep stops the oscillator driver
// [R5] Ports hold their drive during sleep
// [R6] Watchdog reset internal, never drives master_clear
// [R7] Wake on master-clear, watchdog, enabled interrupt
// [R8] Watchdog/interrupt wake continues, no reset
// [R9] Power-down flag set at power-up
// [R10] Watchdog wake clears timeout flag
// [R11] Only listed sources can wake
// [R12] Clocked peripherals cannot interrupt in sleep
// [R13] Prefetch of PC+1 during sleep instruction
// [R14] Wake needs source enable, ignores global enable
// [R15] After wake: in-line, or vector if enabled
// [R16] Pending enabled flag wakes at once
// [R17] Watchdog cleared on every wake
// [R18] Pending interrupt makes sleep a no-op
// [R19] Late interrupt: sleep completes then wakes
// [R20] Start-up delay 1024 periods, skipped some modes
// [R21] Four 7-bit ID words, programming mode only
// [R22] Programming entry: data/clock low, high voltage
// [R23] Config enable forces watchdog, else soft enable
// [R24] Registered sleep state left only by wake
module swc_top
  import swc_pkg::*;
#(
  parameter int OST_CYCLES = SWC_OST_PERIODS
) (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [7:0]  HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // Core side
  input  wire logic        SLEEP_INSTR_IN,
  input  wire logic        WDT_CLEAR_INSTR_IN,
  input  wire logic [6:0]  IRQ_ENABLE_IN,
  input  wire logic [6:0]  IRQ_FLAG_IN,
  input  wire logic        TIMER1_ASYNC_IN,
  input  wire logic        ADC_ON_INTERNAL_RC_IN,
  input  wire logic        GLOBAL_IRQ_ENABLE_IN,
  input  wire logic        MASTER_CLEAR_PIN_IN,
  input  wire logic        PROG_DATA_PIN_IN,
  input  wire logic        PROG_CLOCK_PIN_IN,
  input  wire logic        HIGH_PROGRAM_VOLTAGE_IN,
  output logic             CORE_STALL_OUT,
  output logic             OSC_DRIVER_EN_OUT,
  output logic             IO_HOLD_OUT,
  output logic             PREFETCH_NEXT_OUT,
  output logic             BRANCH_VECTOR_OUT,
  output logic             DEVICE_RESET_OUT,
  output logic             WDT_RESET_OUT,
  output logic             MASTER_CLEAR_DRIVE_OUT,
  output logic             PROG_MODE_OUT,
  output logic             POWER_DOWN_FLAG_OUT,
  output logic             TIMEOUT_FLAG_OUT
);
  // ==========================================
  // State
  initial begin
    if (OST_CYCLES < 1) $error("OST_CYCLES must be at least 1");
    // The start-up counter is 16 bits wide
    if (OST_CYCLES > 65536) $error("OST_CYCLES must be at most 65536");
  end

  typedef struct packed {
    swc_state_t  st;
    logic [7:0]  wdctl;
    logic [7:0]  option;
    logic [7:0]  config_w;
    logic [6:0]  id0, id1, id2, id3;
    logic [19:0] wdt_cnt;
    logic [15:0] ost_cnt;
    logic        pd, to;
    logic        prog;
    logic [2:0]  master_clear_pin_s, vpp_s;
    logic        ph_act, ph_wr;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
    logic        stall, osc, hold, pref, vec, dres, wres;
    // Vector request kept across the start-up delay
    logic        vec_pend;
  } swc_st_t;

  swc_st_t r_reg, r_next;

  logic        wdt_on;
  logic [19:0] wdt_limit;
  logic [6:0]  wake_mask;
  logic        irq_wake;
  logic        master_clear_pin_low;
  logic        vpp_high;
  logic        skip_ost;
  logic [6:0]  ids [SWC_ID_WORDS];

  always_comb begin
    ids[0] = r_reg.id0;
    ids[1] = r_reg.id1;
    ids[2] = r_reg.id2;
    ids[3] = r_reg.id3;
  end

  // ==========================================
  // Wake qualification
  always_comb begin
    wdt_on    = r_reg.config_w[SWC_CFG_WDT_EN_BIT] | r_reg.wdctl[SWC_WD_SOFT_EN_BIT]; // [R23]
    wdt_limit = 20'(SWC_WDT_BASE_CYCLES) << r_reg.wdctl[SWC_WD_PS_LSB +: 4];
    // Bit 0 timer1 counts only when asynchronous; bit 2 A/D only on internal RC
    wake_mask = 7'h7F; // [R11]
    wake_mask[0] = TIMER1_ASYNC_IN; // [R12]
    wake_mask[2] = ADC_ON_INTERNAL_RC_IN; // [R12]
    irq_wake  = |(IRQ_ENABLE_IN & IRQ_FLAG_IN & wake_mask); // [R14] [R16]
    // Active level counts once 2nd and 3rd stages agree; release counts as soon as the 2nd stage has it
    master_clear_pin_low  = ~r_reg.master_clear_pin_s[1] & ~r_reg.master_clear_pin_s[2];
    vpp_high  = r_reg.vpp_s[1] & r_reg.vpp_s[2];
    skip_ost  = (r_reg.config_w[SWC_CFG_FOSC_LSB +: 3] == SWC_FOSC_EC) ||
                (r_reg.config_w[SWC_CFG_FOSC_LSB +: 3] == SWC_FOSC_RC_IO_MODE); // [R20]
  end

  // ==========================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.master_clear_pin_s = {r_reg.master_clear_pin_s[1:0], MASTER_CLEAR_PIN_IN};
    r_next.vpp_s  = {r_reg.vpp_s[1:0], HIGH_PROGRAM_VOLTAGE_IN};
    r_next.pref = 1'b0;
    r_next.vec  = 1'b0;
    r_next.dres = 1'b0;
    r_next.wres = 1'b0;

    // Programming entry: data and clock held low while high voltage rises
    if (vpp_high && !r_reg.prog && !PROG_DATA_PIN_IN && !PROG_CLOCK_PIN_IN) begin
      r_next.prog = 1'b1; // [R22]
    end else if (!vpp_high) begin
      r_next.prog = 1'b0;
    end

    // Watchdog counts in run and sleep; held at zero during the start-up delay
    if (!wdt_on || WDT_CLEAR_INSTR_IN) begin
      r_next.wdt_cnt = '0;
    end else if (r_reg.wdt_cnt + 20'h0_0001 >= wdt_limit) begin
      r_next.wdt_cnt = '0;
    end else begin
      r_next.wdt_cnt = r_reg.wdt_cnt + 20'h0_0001; // [R2]
    end

    case (r_reg.st)
      SWC_RUN: begin
        if (wdt_on && !WDT_CLEAR_INSTR_IN && r_reg.wdt_cnt + 20'h0_0001 >= wdt_limit) begin
          // Internal reset only; master clear pin is never driven
          r_next.wres = 1'b1; // [R6]
          r_next.to   = 1'b0;
        end
        if (SLEEP_INSTR_IN) begin // [R1]
          r_next.pref = 1'b1; // [R13]
          if (!irq_wake) begin
            r_next.st      = SWC_SLEEP; // [R24]
            r_next.wdt_cnt = '0; // [R2]
            r_next.pd      = 1'b0; // [R3] [R9]
            r_next.to      = 1'b1; // [R3]
            r_next.osc     = 1'b0; // [R4]
            r_next.hold    = 1'b1; // [R5]
            r_next.stall   = 1'b1;
          end
          // Pending enabled interrupt: sleep is a no-op, only the prefetch pulses [R18]
        end
      end
      SWC_SLEEP: begin
        // Late interrupt after entry wakes on next cycle [R19]
        if (master_clear_pin_low) begin
          r_next.dres  = 1'b1; // [R7]
          r_next.st    = SWC_RUN;
          r_next.stall = 1'b0;
          r_next.osc   = 1'b1;
          r_next.hold  = 1'b0;
          r_next.wdt_cnt = '0; // [R17]
        end else if (irq_wake ||
                     (wdt_on && r_reg.wdt_cnt + 20'h0_0001 >= wdt_limit)) begin
          if (!irq_wake) begin
            r_next.to = 1'b0; // [R10]
          end
          r_next.vec_pend = irq_wake & GLOBAL_IRQ_ENABLE_IN; // [R15]
          r_next.vec      = skip_ost & irq_wake & GLOBAL_IRQ_ENABLE_IN;
          r_next.osc     = 1'b1;
          r_next.wdt_cnt = '0; // [R17]
          r_next.ost_cnt = '0;
          r_next.st      = skip_ost ? SWC_RUN : SWC_OST; // [R8] [R20]
          r_next.stall   = ~skip_ost;
          r_next.hold    = 1'b0;
        end
      end
      SWC_OST: begin
        r_next.wdt_cnt = '0;
        if (r_reg.ost_cnt == 16'(OST_CYCLES - 1)) begin
          r_next.st    = SWC_RUN; // [R20]
          r_next.stall = 1'b0;
        end else begin
          r_next.ost_cnt = r_reg.ost_cnt + 16'h0001;
        end
        r_next.vec = r_reg.vec_pend & (r_reg.ost_cnt == 16'(OST_CYCLES - 1)); // [R15]
      end
      default: r_next.st = SWC_RUN;
    endcase

    // Master clear outside sleep also resets unless in programming mode, sleep state already handled
    if (r_reg.st != SWC_SLEEP && master_clear_pin_low && !r_reg.prog) begin
      r_next.dres = 1'b1;
    end

    // ==========================================
    // AHB-Lite data phase
    r_next.ph_act = HSEL_IN && HREADY_IN && HTRANS_IN == SWC_HTRANS_NONSEQ;
    r_next.ph_wr  = HWRITE_IN;
    r_next.ph_addr = HADDR_IN;
    if (r_reg.ph_act && r_reg.ph_wr) begin
      case (r_reg.ph_addr)
        SWC_ADDR_WDCTL:  r_next.wdctl    = HWDATA_IN[7:0] & SWC_WDCTL_MASK;
        SWC_ADDR_OPTION: r_next.option   = HWDATA_IN[7:0];
        SWC_ADDR_CONFIG: r_next.config_w = HWDATA_IN[7:0];
        default: begin
          if (r_reg.prog && r_reg.ph_addr[7:4] == SWC_ADDR_ID0[7:4]) begin
            case (r_reg.ph_addr[3:2])
              2'h0:    r_next.id0 = HWDATA_IN[6:0] & SWC_ID_MASK; // [R21]
              2'h1:    r_next.id1 = HWDATA_IN[6:0] & SWC_ID_MASK;
              2'h2:    r_next.id2 = HWDATA_IN[6:0] & SWC_ID_MASK;
              default: r_next.id3 = HWDATA_IN[6:0] & SWC_ID_MASK;
            endcase
          end
        end
      endcase
    end
    r_next.rdata = 32'h0000_0000;
    if (HSEL_IN && HREADY_IN && HTRANS_IN == SWC_HTRANS_NONSEQ && !HWRITE_IN) begin
      case (HADDR_IN)
        SWC_ADDR_WDCTL:  r_next.rdata = {24'h00_0000, r_reg.wdctl};
        SWC_ADDR_OPTION: r_next.rdata = {24'h00_0000, r_reg.option};
        SWC_ADDR_CONFIG: r_next.rdata = {24'h00_0000, r_reg.config_w};
        SWC_ADDR_STATUS: r_next.rdata = {28'h000_0000, r_reg.prog, r_reg.st == SWC_SLEEP,
                                         r_reg.pd, r_reg.to};
        SWC_ADDR_PROG:   r_next.rdata = {31'h0000_0000, r_reg.prog};
        default: begin
          if (r_reg.prog && HADDR_IN[7:4] == SWC_ADDR_ID0[7:4]) begin
            r_next.rdata = {25'h000_0000, ids[HADDR_IN[3:2]]}; // [R21]
          end
        end
      endcase
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      r_reg          <= '0;
      r_reg.st       <= SWC_RUN;
      r_reg.wdctl    <= SWC_WDCTL_RST;
      r_reg.option   <= SWC_OPTION_RST;
      r_reg.config_w <= SWC_CONFIG_RST;
      r_reg.pd       <= 1'b1; // [R9]
      r_reg.to       <= 1'b1;
      r_reg.osc      <= 1'b1;
      r_reg.master_clear_pin_s   <= 3'h7;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs, straight from flip-flops or tied to constants
  always_comb begin
    HRDATA_OUT             = r_reg.rdata;
    HREADYOUT_OUT          = 1'b1;
    HRESP_OUT              = 1'b0;
    CORE_STALL_OUT         = r_reg.stall;
    OSC_DRIVER_EN_OUT      = r_reg.osc;
    IO_HOLD_OUT            = r_reg.hold;
    PREFETCH_NEXT_OUT      = r_reg.pref;
    BRANCH_VECTOR_OUT      = r_reg.vec;
    DEVICE_RESET_OUT       = r_reg.dres;
    WDT_RESET_OUT          = r_reg.wres;
    MASTER_CLEAR_DRIVE_OUT = 1'b0; // [R6]
    PROG_MODE_OUT          = r_reg.prog;
    POWER_DOWN_FLAG_OUT    = r_reg.pd;
    TIMEOUT_FLAG_OUT       = r_reg.to;
  end
endmodule

// ---- dv/swc_assertions.sv ----
`timescale 1ns/1ps
// ==========
// Pin checks beside the sleep controller
module swc_assertions #(parameter int OST_CYCLES = 1024) (
  // Inputs
  input wire logic       CLK_IN, SRST_IN, SLEEP_INSTR_IN, TIMER1_ASYNC_IN, ADC_ON_INTERNAL_RC_IN,
  input wire logic       GLOBAL_IRQ_ENABLE_IN, MASTER_CLEAR_PIN_IN,
  input wire logic [6:0] IRQ_ENABLE_IN, IRQ_FLAG_IN,
  // Outputs
  input wire logic       CORE_STALL_OUT, OSC_DRIVER_EN_OUT, IO_HOLD_OUT, PREFETCH_NEXT_OUT, BRANCH_VECTOR_OUT,
  input wire logic       WDT_RESET_OUT, MASTER_CLEAR_DRIVE_OUT, POWER_DOWN_FLAG_OUT, TIMEOUT_FLAG_OUT
);
  // Timer1 and A/D only count as wake sources when they do not run off the core clock
  logic pend;
  assign pend = |(IRQ_ENABLE_IN & IRQ_FLAG_IN & {4'hF, ADC_ON_INTERNAL_RC_IN, 1'b1, TIMER1_ASYNC_IN});
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_go; SLEEP_INSTR_IN && !CORE_STALL_OUT && MASTER_CLEAR_PIN_IN; endsequence
  sequence s_wake; $rose(OSC_DRIVER_EN_OUT) && CORE_STALL_OUT; endsequence
  sleep_entry_a: assert property (s_go ##0 !pend |=> CORE_STALL_OUT && !OSC_DRIVER_EN_OUT && IO_HOLD_OUT &&
    PREFETCH_NEXT_OUT && !POWER_DOWN_FLAG_OUT && TIMEOUT_FLAG_OUT) else $error("sleep entry wrong");
  sleep_noop_a: assert property (s_go ##0 pend |=> !CORE_STALL_OUT && $stable(POWER_DOWN_FLAG_OUT))
    else $error("pending sleep not a no-op");
  osc_hold_a: assert property (!OSC_DRIVER_EN_OUT |-> CORE_STALL_OUT && IO_HOLD_OUT)
    else $error("ports not held with oscillator off");
  master_clear_pin_drive_a: assert property (!MASTER_CLEAR_DRIVE_OUT) else $error("master clear driven");
  irq_wake_a: assert property (!OSC_DRIVER_EN_OUT && pend |=> OSC_DRIVER_EN_OUT && !IO_HOLD_OUT)
    else $error("enabled interrupt did not wake");
  vector_gie_a: assert property (BRANCH_VECTOR_OUT |-> GLOBAL_IRQ_ENABLE_IN)
    else $error("vector without global enable");
  ost_delay_a: assert property (s_wake |-> CORE_STALL_OUT[*3] ##[1:8] !CORE_STALL_OUT)
    else $error("start-up delay wrong");
  wdt_noreset_a: assert property (!OSC_DRIVER_EN_OUT |=> !WDT_RESET_OUT)
    else $error("reset on wake");
endmodule
bind swc_top swc_assertions #(.OST_CYCLES(OST_CYCLES)) i_swc_assertions (.CLK_IN, .SRST_IN, .SLEEP_INSTR_IN,
  .TIMER1_ASYNC_IN, .ADC_ON_INTERNAL_RC_IN, .GLOBAL_IRQ_ENABLE_IN, .MASTER_CLEAR_PIN_IN, .IRQ_ENABLE_IN,
  .IRQ_FLAG_IN, .CORE_STALL_OUT, .OSC_DRIVER_EN_OUT, .IO_HOLD_OUT, .PREFETCH_NEXT_OUT, .BRANCH_VECTOR_OUT,
  .WDT_RESET_OUT, .MASTER_CLEAR_DRIVE_OUT, .POWER_DOWN_FLAG_OUT, .TIMEOUT_FLAG_OUT);

// ---- dv/swc_core_model.sv ----
`timescale 1ns/1ps
// ==========
// Core sequencer and interrupt sources
module swc_core_model (
  input  wire logic       clk_in,
  input  wire logic       sleep_req_in,
  input  wire logic [6:0] src_event_in,
  input  wire logic       flag_clear_in,
  output logic            sleep_instr_out,
  output logic [6:0]      irq_flag_out
);
  logic req_reg;
  always_ff @(posedge clk_in) begin
    req_reg <= sleep_req_in;
    // One instruction per request, never repeated while held
    sleep_instr_out <= sleep_req_in && !req_reg;
    // Flags stay set until software clears them
    irq_flag_out <= flag_clear_in ? 7'h00 : (irq_flag_out | src_event_in);
  end
endmodule

// ---- dv/swc_top_tb.sv ----
`timescale 1ns/1ps
// ==========
// Bench for the sleep controller
module swc_top_tb;
  import swc_pkg::*;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, sleep_req = 0, flag_clr = 1, global_irq_enable = 0, master_clear_pin_n = 1, t1_async = 0;
  logic vpp = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0;
  logic [6:0] irq_en = 0, src_evt = 0;
  wire logic [31:0] hrdata;
  wire logic [6:0] irq_flag;
  wire logic hrdy, stall, osc, hold, vec, devrst, wdtrst, pd, to, pref, sleep_instr;
  int mismatches = 0, checks_done = 0, vec_cnt = 0, dev_cnt = 0, wdt_cnt = 0, v, d, w;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (vec === 1'b1) vec_cnt++;
    if (devrst === 1'b1) dev_cnt++;
    if (wdtrst === 1'b1) wdt_cnt++;
  end
  swc_top #(.OST_CYCLES(4)) i_swc_top (.CLK_IN(clk), .SRST_IN(srst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .SLEEP_INSTR_IN(sleep_instr),
    .WDT_CLEAR_INSTR_IN(1'b0), .IRQ_ENABLE_IN(irq_en), .IRQ_FLAG_IN(irq_flag), .TIMER1_ASYNC_IN(t1_async),
    .ADC_ON_INTERNAL_RC_IN(1'b0), .GLOBAL_IRQ_ENABLE_IN(global_irq_enable), .MASTER_CLEAR_PIN_IN(master_clear_pin_n),
    .PROG_DATA_PIN_IN(1'b0), .PROG_CLOCK_PIN_IN(1'b0), .HIGH_PROGRAM_VOLTAGE_IN(vpp), .CORE_STALL_OUT(stall),
    .OSC_DRIVER_EN_OUT(osc), .IO_HOLD_OUT(hold), .PREFETCH_NEXT_OUT(pref), .BRANCH_VECTOR_OUT(vec),
    .DEVICE_RESET_OUT(devrst), .WDT_RESET_OUT(wdtrst), .MASTER_CLEAR_DRIVE_OUT(), .PROG_MODE_OUT(),
    .POWER_DOWN_FLAG_OUT(pd), .TIMEOUT_FLAG_OUT(to));
  swc_core_model i_swc_core_model (.clk_in(clk), .sleep_req_in(sleep_req), .src_event_in(src_evt),
    .flag_clear_in(flag_clr), .sleep_instr_out(sleep_instr), .irq_flag_out(irq_flag));
  // ==========
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask
  // Hang guard shared by every wait
  task automatic wait_for(input bit rdy_not_stall, input int lim);
    int n;
    n = 0;
    while ((rdy_not_stall ? hrdy !== 1'b1 : stall !== 1'b0) && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (rdy_not_stall ? hrdy !== 1'b1 : stall !== 1'b0) begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= SWC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= SWC_HSIZE_WORD;
    @(negedge clk);
    wait_for(1'b1, 50);
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(negedge clk);
    wait_for(1'b1, 50);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic [31:0] x;
    bus(1'b1, a, dat, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask
  task automatic go_sleep;
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input logic [6:0] e, input logic clr);
    @(posedge clk);
    src_evt <= e;
    flag_clr <= clr;
    @(posedge clk);
    src_evt <= 7'h00;
    flag_clr <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    rdc(SWC_ADDR_WDCTL, 32'h0000_0008);
    rdc(SWC_ADDR_STATUS, 32'h0000_0003);
    wr(SWC_ADDR_ID0, 32'h0000_007F);
    rdc(SWC_ADDR_ID0, 32'h0000_0000);
    rdc(8'h3C, 32'h0000_0000);
    $display("registers done");
  endtask
  // Data and clock pins stay low while the high voltage rises
  task automatic t_prog;
    vpp <= 1'b1;
    repeat (5) @(posedge clk);
    rdc(SWC_ADDR_PROG, 32'h0000_0001);
    wr(SWC_ADDR_ID0, 32'h0000_00FF);
    rdc(SWC_ADDR_ID0, 32'h0000_007F);
    vpp <= 1'b0;
    repeat (5) @(posedge clk);
    rdc(SWC_ADDR_PROG, 32'h0000_0000);
    $display("programming mode done");
  endtask
  task automatic t_noop;
    irq_en <= 7'h41;
    pulse(7'h40, 1'b0);
    go_sleep;
    chk(stall, 1'b0);
    chk(pd, 1'b1);
    pulse(7'h00, 1'b1);
    $display("pending no-op done");
  endtask
  task automatic t_irq;
    global_irq_enable <= 1'b1;
    go_sleep;
    chk({stall, osc, hold, pref}, 4'hB);
    chk({pd, to}, 2'h1);
    v = vec_cnt;
    // Timer1 off the core clock must not wake
    pulse(7'h01, 1'b0);
    repeat (6) @(negedge clk);
    chk(stall, 1'b1);
    pulse(7'h40, 1'b0);
    wait_for(1'b0, 20);
    @(negedge clk);
    chk(vec_cnt - v, 1);
    chk({osc, pd}, 2'h2);
    pulse(7'h00, 1'b1);
    $display("interrupt wake done");
  endtask
  task automatic t_ec;
    wr(SWC_ADDR_CONFIG, 32'h0000_0003);
    global_irq_enable <= 1'b0;
    t1_async <= 1'b1;
    go_sleep;
    v = vec_cnt;
    pulse(7'h01, 1'b0);
    wait_for(1'b0, 4);
    chk(vec_cnt - v, 0);
    pulse(7'h00, 1'b1);
    t1_async <= 1'b0;
    $display("fast clock wake done");
  endtask
  task automatic t_wdt;
    wr(SWC_ADDR_WDCTL, 32'h0000_0001);
    w = wdt_cnt;
    d = dev_cnt;
    go_sleep;
    wait_for(1'b0, 200);
    chk(to, 1'b0);
    chk(wdt_cnt - w + dev_cnt - d, 0);
    wr(SWC_ADDR_WDCTL, 32'h0000_0000);
    $display("watchdog wake done");
  endtask
  task automatic t_master_clear_pin;
    go_sleep;
    d = dev_cnt;
    @(posedge clk);
    master_clear_pin_n <= 1'b0;
    wait_for(1'b0, 10);
    @(negedge clk);
    chk(dev_cnt - d, 1);
    master_clear_pin_n <= 1'b1;
    $display("master clear wake done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    flag_clr <= 1'b0;
    t_regs;
    t_prog;
    t_noop;
    t_irq;
    t_ec;
    t_wdt;
    t_master_clear_pin;
    wrap_up();
  end
endmodule
